// ==== alu_host_pkg.sv ====
// Shared constants, pin bundles and state types for the ALU slice host controller
package alu_host_pkg;

  // ***************************************************
  // Geometry
  // ***************************************************
  localparam int SLICES = 4;
  localparam int SLICE_W = 4;
  localparam int WORD_W = SLICES * SLICE_W;
  localparam int SYNC_STAGES = 2;

  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_PERIOD_NS = 50;
  // Combinational settle time allowed for slice and lookahead pins
  localparam int SETTLE_NS = 100;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_CYC = SETTLE_CYC + SYNC_STAGES;
  localparam logic [3:0] WAIT_LOAD = 4'(WAIT_CYC);

  // ***************************************************
  // Reset values and last slice index
  // ***************************************************
  localparam logic [SLICES-1:0] PG_IDLE_N = 4'hf;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [1:0] LAST_SLICE = 2'h3;

  // ***************************************************
  // Bundles
  // ***************************************************
  typedef struct packed {
    logic lookahead;
    logic [3:0] function_select;
    logic logic_mode;
    logic carry_input;
    logic [WORD_W-1:0] operand_a;
    logic [WORD_W-1:0] operand_b;
  } op_req_s;

  typedef struct packed {
    logic [WORD_W-1:0] result_bits;
    logic carry_out;
    logic a_eq_b;
    logic a_gt_b;
    logic a_lt_b;
    logic group_propagate_n;
    logic group_generate_n;
  } op_resp_s;

  typedef struct packed {
    logic [3:0] function_select;
    logic logic_mode;
    logic [SLICES-1:0] carry_input;
    logic [WORD_W-1:0] operand_a;
    logic [WORD_W-1:0] operand_b;
  } slice_drive_s;

  typedef struct packed {
    logic [SLICES-1:0] slice_propagate_in_n;
    logic [SLICES-1:0] slice_generate_in_n;
    logic carry_input;
  } look_drive_s;

  typedef struct packed {
    logic [WORD_W-1:0] result_bits;
    logic [SLICES-1:0] ripple_carry_output;
    logic [SLICES-1:0] propagate_n;
    logic [SLICES-1:0] generate_n;
    logic equal_line;
    logic [2:0] lookahead_carry;
    logic group_propagate_n;
    logic group_generate_n;
  } pin_in_s;

  localparam int PIN_IN_W = $bits(pin_in_s);

  typedef enum logic [2:0] {ST_IDLE, ST_RIPPLE, ST_GROUP, ST_LOOK, ST_FINAL} host_st_e;

  typedef struct packed {
    host_st_e st;
    logic [3:0] cnt;
    logic [1:0] idx;
    logic ready;
    slice_drive_s slice;
    look_drive_s look;
    logic resp_valid;
    op_resp_s resp;
  } host_state_s;

endpackage

// ==== pin_sync.sv ====
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bundle
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_s;

  sync_state_s s_reg;
  sync_state_s s_next;

  // First stage feeds only the second stage
  always_comb begin
    s_next = s_reg;
    s_next.meta = async_in;
    s_next.stable = s_reg.meta;
  end

  // Register stages
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.stable;

endmodule

// ==== alu_slice_host.sv ====
// Host controller that drives four ALU slices and one carry lookahead generator
`timescale 1ns/100ps
module alu_slice_host (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Operation request
  input wire logic req_valid,
  output logic req_ready,
  input wire alu_host_pkg::op_req_s req,
  // Operation answer
  output logic resp_valid,
  output alu_host_pkg::op_resp_s resp,
  // Slice pins driven
  output alu_host_pkg::slice_drive_s slice_pins,
  // Lookahead generator pins driven
  output alu_host_pkg::look_drive_s look_pins,
  // Slice and generator pins sensed
  input wire alu_host_pkg::pin_in_s pin_in
);

  import alu_host_pkg::*;

  // ***************************************************
  // Pin synchronisation
  // ***************************************************
  logic [PIN_IN_W-1:0] pin_sync_bits;
  pin_in_s syn;

  pin_sync #(
    .WIDTH(PIN_IN_W)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(pin_in),
    .sync_out(pin_sync_bits)
  );

  assign syn = pin_in_s'(pin_sync_bits);

  // ***************************************************
  // Sequencer
  // ***************************************************
  host_state_s s_reg;
  host_state_s s_next;

  // Next-state logic; every wait covers settle time plus synchroniser delay
  always_comb begin
    s_next = s_reg;
    s_next.resp_valid = 1'b0;
    case (s_reg.st)
      ST_IDLE: begin
        if (req_valid) begin
          s_next.ready = 1'b0;
          s_next.slice.function_select = req.function_select;
          s_next.slice.logic_mode = req.logic_mode;
          s_next.slice.operand_a = req.operand_a;
          s_next.slice.operand_b = req.operand_b;
          s_next.slice.carry_input = {3'h0, req.carry_input};
          s_next.look.slice_propagate_in_n = PG_IDLE_N;
          s_next.look.slice_generate_in_n = PG_IDLE_N;
          s_next.look.carry_input = 1'b0;
          s_next.cnt = WAIT_LOAD;
          s_next.idx = 2'h0;
          s_next.st = req.lookahead ? ST_GROUP : ST_RIPPLE;
        end
      end
      ST_RIPPLE: begin
        if (s_reg.cnt != CNT_RESET) begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end else if (s_reg.idx == LAST_SLICE) begin
          s_next.st = ST_FINAL;
        end else begin
          s_next.slice.carry_input[s_reg.idx + 2'h1] = syn.ripple_carry_output[s_reg.idx];
          s_next.idx = s_reg.idx + 2'h1;
          s_next.cnt = WAIT_LOAD;
        end
      end
      ST_GROUP: begin
        if (s_reg.cnt != CNT_RESET) begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end else begin
          s_next.look.slice_propagate_in_n = syn.propagate_n;
          s_next.look.slice_generate_in_n = syn.generate_n;
          s_next.look.carry_input = s_reg.slice.carry_input[0];
          s_next.cnt = WAIT_LOAD;
          s_next.st = ST_LOOK;
        end
      end
      ST_LOOK: begin
        if (s_reg.cnt != CNT_RESET) begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end else begin
          s_next.slice.carry_input[3:1] = syn.lookahead_carry;
          s_next.cnt = WAIT_LOAD;
          s_next.st = ST_FINAL;
        end
      end
      ST_FINAL: begin
        if (s_reg.cnt != CNT_RESET) begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end else begin
          s_next.resp.result_bits = syn.result_bits;
          s_next.resp.carry_out = syn.ripple_carry_output[3];
          s_next.resp.a_eq_b = syn.equal_line;
          s_next.resp.a_gt_b = syn.ripple_carry_output[3] & ~syn.equal_line;
          // Equal operands leave no carry, so less-than must exclude equality
          s_next.resp.a_lt_b = ~syn.ripple_carry_output[3] & ~syn.equal_line;
          s_next.resp.group_propagate_n = syn.group_propagate_n;
          s_next.resp.group_generate_n = syn.group_generate_n;
          s_next.resp_valid = 1'b1;
          s_next.ready = 1'b1;
          s_next.st = ST_IDLE;
        end
      end
      default: begin
        s_next.st = ST_IDLE;
        s_next.ready = 1'b1;
      end
    endcase
  end

  // State register; generator P/G inputs idle inactive (high) after reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.ready <= 1'b1;
      s_reg.look.slice_propagate_in_n <= PG_IDLE_N;
      s_reg.look.slice_generate_in_n <= PG_IDLE_N;
      s_reg.resp.group_propagate_n <= 1'b1;
      s_reg.resp.group_generate_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign req_ready = s_reg.ready;
  assign resp_valid = s_reg.resp_valid;
  assign resp = s_reg.resp;
  assign slice_pins = s_reg.slice;
  assign look_pins = s_reg.look;

  // ***************************************************
  // Checks
  // ***************************************************
  logic [1:0] idx_up;
  assign idx_up = s_reg.idx + 2'h1;

  AST_RIPPLE_CHAIN: assert property (@(posedge core_clk) disable iff (rst)
    (s_reg.st == ST_RIPPLE && s_reg.cnt == CNT_RESET && s_reg.idx != LAST_SLICE)
    |=> slice_pins.carry_input[$past(idx_up)] == $past(syn.ripple_carry_output[s_reg.idx]))
    else $error("ripple carry not chained to next slice");

  AST_LOOK_CARRY: assert property (@(posedge core_clk) disable iff (rst)
    (s_reg.st == ST_LOOK && s_reg.cnt == CNT_RESET)
    |=> slice_pins.carry_input[3:1] == $past(syn.lookahead_carry) ##[3:3] s_reg.st == ST_FINAL)
    else $error("lookahead carries not applied to slices");

  AST_LOOK_WIRING: assert property (@(posedge core_clk) disable iff (rst)
    (s_reg.st == ST_GROUP && s_reg.cnt == CNT_RESET)
    |=> look_pins.slice_propagate_in_n == $past(syn.propagate_n)
        && look_pins.slice_generate_in_n == $past(syn.generate_n)
        && look_pins.carry_input == slice_pins.carry_input[0])
    else $error("slice P/G not passed unchanged to generator");

  AST_COMPARE: assert property (@(posedge core_clk) disable iff (rst)
    $rose(resp_valid) |-> resp.a_lt_b == (!$past(syn.ripple_carry_output[3]) && !$past(syn.equal_line))
      && resp.a_gt_b == ($past(syn.ripple_carry_output[3]) && !$past(syn.equal_line)))
    else $error("greater/less not derived from carry and equality");

  AST_RIPPLE_DONE: assert property (@(posedge core_clk) disable iff (rst)
    (s_reg.st == ST_IDLE && req_valid && !req.lookahead) |-> ##22 resp_valid)
    else $error("ripple operation latency out of range");

  AST_LOOK_DONE: assert property (@(posedge core_clk) disable iff (rst)
    (s_reg.st == ST_IDLE && req_valid && req.lookahead) |-> ##16 resp_valid)
    else $error("lookahead operation latency out of range");

endmodule

// ==== alu_slice_model.sv ====
// Behavioural four-slice ALU group plus one carry lookahead generator
`timescale 1ns/100ps
module alu_slice_model #(
  parameter int DLY = 40
) (
  // Host-driven pins
  input wire alu_host_pkg::slice_drive_s slice_pins,
  input wire alu_host_pkg::look_drive_s look_pins,
  // Sensed pins
  output wire alu_host_pkg::pin_in_s pin_in
);
  import alu_host_pkg::*;
  pin_in_s nxt;
  logic [3:0] a, b, s, t1, t2, f, p, g;
  logic [4:0] sum;
  logic c;
  // ****
  // Slices and generator
  // ****
  // Combinational view of all five parts
  always_comb begin
    nxt = '0;
    nxt.equal_line = 1'b1;
    s = slice_pins.function_select;
    for (int i = 0; i < SLICES; i++) begin
      a = slice_pins.operand_a[4*i +: 4];
      b = slice_pins.operand_b[4*i +: 4];
      t1 = a | (b & {4{s[0]}}) | (~b & {4{s[1]}});
      t2 = (a & ~b & {4{s[2]}}) | (a & b & {4{s[3]}});
      sum = 5'(t1) + 5'(t2) + 5'(slice_pins.carry_input[i]);
      f = slice_pins.logic_mode ? ~(t1 ^ t2) : sum[3:0];
      nxt.result_bits[4*i +: 4] = f;
      nxt.ripple_carry_output[i] = sum[4];
      nxt.propagate_n[i] = ~&t1;
      nxt.generate_n[i] = ~((5'(t1) + 5'(t2)) > 5'hf);
      nxt.equal_line = nxt.equal_line & (&f);
    end
    p = ~look_pins.slice_propagate_in_n;
    g = ~look_pins.slice_generate_in_n;
    c = look_pins.carry_input;
    nxt.lookahead_carry[0] = g[0] | (p[0] & c);
    nxt.lookahead_carry[1] = g[1] | (p[1] & g[0]) | (p[1] & p[0] & c);
    nxt.lookahead_carry[2] = g[2] | (p[2] & g[1]) | (p[2] & p[1] & g[0]) | (&p[2:0] & c);
    nxt.group_generate_n = ~(g[3] | (p[3] & g[2]) | (&p[3:2] & g[1]) | (&p[3:1] & g[0]));
    nxt.group_propagate_n = ~&p;
  end
  // Slow settle, still inside the host's window
  assign #(DLY) pin_in = nxt;
endmodule

// ==== tb_alu_slice_host.sv ====
// Self-checking bench for the ALU slice host controller
`timescale 1ns/100ps
module tb_alu_slice_host;
  import alu_host_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_ready, resp_valid;
  op_req_s req = '0;
  op_resp_s resp;
  slice_drive_s slice_pins;
  look_drive_s look_pins;
  pin_in_s pin_in;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  // ****
  // Clock, parts, watchdog
  // ****
  always #25 core_clk = ~core_clk;
  alu_slice_host uut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .resp_valid(resp_valid), .resp(resp), .slice_pins(slice_pins), .look_pins(look_pins),
    .pin_in(pin_in));
  alu_slice_model far_end (.slice_pins(slice_pins), .look_pins(look_pins), .pin_in(pin_in));
  // Cuts a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      complete_run();
    end
  end
  // ****
  // Shared tasks
  // ****
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Word-level answer, worked out independently
  function automatic op_resp_s expect_resp(op_req_s r);
    logic [15:0] t1, t2;
    logic [16:0] sum;
    op_resp_s e;
    t1 = r.operand_a | (r.operand_b & {16{r.function_select[0]}}) | (~r.operand_b & {16{r.function_select[1]}});
    t2 = (r.operand_a & ~r.operand_b & {16{r.function_select[2]}}) |
      (r.operand_a & r.operand_b & {16{r.function_select[3]}});
    sum = 17'(t1) + 17'(t2) + 17'(r.carry_input);
    e.result_bits = r.logic_mode ? ~(t1 ^ t2) : sum[15:0];
    e.carry_out = sum[16];
    e.a_eq_b = &e.result_bits;
    e.a_gt_b = sum[16] & ~e.a_eq_b;
    e.a_lt_b = ~sum[16] & ~e.a_eq_b;
    e.group_propagate_n = ~(r.lookahead & (&t1));
    e.group_generate_n = ~(r.lookahead & ((17'(t1) + 17'(t2)) > 17'hffff));
    return e;
  endfunction
  // Waits for the answer from cycle n on, then judges it
  task automatic wait_check(input op_req_s r, input int n);
    while (resp_valid !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    check("latency", n, r.lookahead ? 16 : 22);
    check("resp", resp, expect_resp(r));
  endtask
  // One request; entered and left at a falling edge
  task automatic do_op(input op_req_s r);
    check("ready", req_ready, 1'b1);
    req = r;
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    wait_check(r, 1);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic test_reset();
    check("ready", req_ready, 1'b1);
    check("slice", slice_pins, 0);
    check("look", look_pins, 9'h1fe);
    check("resp", resp, 22'h3);
  endtask
  task automatic test_logic();
    for (int k = 0; k < 16; k++) begin
      do_op({k[0], 4'(k), 1'b1, k[1], 16'h5a3c, 16'h0ff0});
    end
  endtask
  task automatic test_arith();
    for (int k = 0; k < 32; k++) begin
      do_op({k[0] ^ k[4], 4'(k), 1'b0, k[4], 16'hc3a7, 16'h5e19});
    end
  endtask
  task automatic test_add_flags();
    logic [15:0] av[3] = '{16'hfff0, 16'hffff, 16'h1234};
    logic [15:0] bv[3] = '{16'h000f, 16'h0001, 16'h0001};
    for (int k = 0; k < 6; k++) begin
      do_op({1'b1, 4'h9, 1'b0, k[0], av[k/2], bv[k/2]});
    end
  endtask
  task automatic test_subtract();
    logic [15:0] av[3] = '{16'h7007, 16'h9003, 16'h3009};
    logic [15:0] bv[3] = '{16'h7007, 16'h3009, 16'h9003};
    for (int k = 0; k < 12; k++) begin
      do_op({k[0], 4'h6, 1'b0, k[1], av[k/4], bv[k/4]});
      // Without carry in the answer is A-B-1, so the flags compare the operands
      if (!k[1]) begin
        check("a_eq_b", resp.a_eq_b, av[k/4] == bv[k/4]);
        check("a_gt_b", resp.a_gt_b, av[k/4] > bv[k/4]);
        check("a_lt_b", resp.a_lt_b, av[k/4] < bv[k/4]);
      end
    end
  endtask
  // A request raised while busy must leave no trace
  task automatic test_refused();
    op_req_s r1 = {1'b1, 4'h9, 1'b0, 1'b0, 16'h0123, 16'h4567};
    int n = 0;
    req = r1;
    req_valid = 1'b1;
    @(negedge core_clk);
    req = {1'b0, 4'h6, 1'b0, 1'b1, 16'hffff, 16'h0001};
    repeat (4) @(negedge core_clk);
    check("busy", req_ready, 1'b0);
    req_valid = 1'b0;
    wait_check(r1, 5);
    repeat (30) begin
      @(negedge core_clk);
      n += int'(resp_valid === 1'b1);
    end
    check("extra", n, 0);
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    test_reset();
    test_logic();
    test_arith();
    test_add_flags();
    test_subtract();
    test_refused();
    complete_run();
  end
endmodule
